// *** pkg/wlm_pkg.sv ***
// constants and types shared by the write leveling logic
// assumes a 50 ns pclk and an APB master with 32-bit data
package wlm_pkg;

  // clock and timing figures, in ns
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_MOD_NS = 600;
  localparam int unsigned T_WLDQSEN_NS = 500;
  localparam int unsigned T_WLO_NS = 400;

  // least times round up, longest times round down, never below one
  localparam int unsigned MOD_RAW = (T_MOD_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int unsigned MOD_CYC = (MOD_RAW < 1) ? 1 : MOD_RAW;
  localparam int unsigned WLDQSEN_RAW = T_WLDQSEN_NS / CLK_PERIOD_NS;
  localparam int unsigned WLDQSEN_CYC = (WLDQSEN_RAW < 1) ? 1 : WLDQSEN_RAW;
  localparam int unsigned WLO_RAW = T_WLO_NS / CLK_PERIOD_NS;
  localparam int unsigned WLO_CYC = (WLO_RAW < 1) ? 1 : WLO_RAW;

  // mode register fields
  localparam logic [2:0] MR1_SEL = 3'h1;
  localparam int unsigned MR1_LEVEL_BIT = 7;
  localparam int unsigned MR1_QOFF_BIT = 12;
  localparam logic [15:0] MR1_RESET = 16'h0000;
  // a12-a11, a9, a7, a6-a5, a2-a1
  localparam logic [15:0] MR1_EXIT_MASK = 16'h1ae6;

  // register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] MR1_OFS = 12'h008;
  localparam int unsigned CTRL_PRIME_BIT = 0;
  localparam logic CTRL_PRIME_RESET = 1'b0;
  localparam int unsigned ST_LEVEL = 0;
  localparam int unsigned ST_QOFF = 1;
  localparam int unsigned ST_TERM = 2;
  localparam int unsigned ST_ODT_OK = 3;
  localparam int unsigned ST_UNDEF = 4;
  localparam int unsigned ST_UPPER = 5;
  localparam int unsigned ST_LOWER = 6;
  localparam int unsigned ST_EXIT = 7;

  // synchronised pin inputs
  localparam int unsigned IN_CK = 0;
  localparam int unsigned IN_US = 1;
  localparam int unsigned IN_LS = 2;
  localparam int unsigned IN_ODT = 3;
  localparam int unsigned IN_MRS = 4;
  localparam int unsigned IN_W = 5;

  typedef enum logic [1:0] {
    WLM_OFF,
    WLM_ON,
    WLM_EXIT
  } wlm_mode_t;

endpackage

// *** logic/wlm_sync.sv ***
// three-stage pin synchroniser with a settled level and a rise pulse
// assumes inputs from outside the pclk domain, held for 3 pclk or more
`timescale 1ns/100ps
module wlm_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  // settled view
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rise;
  } wlm_sync_t;

  wlm_sync_t r;
  wlm_sync_t next_r;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb begin
    next_r = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.lvl[i] = r.s3[i];
      end
      next_r.rise[i] = (r.s2[i] == r.s3[i]) && r.s3[i] && !r.lvl[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.lvl;
  assign rise = r.rise;

endmodule // wlm_sync

// *** logic/wlm_write_leveling.sv ***
// device-side write leveling: mode register 1 shadow, strobe termination,
// clock sampling on strobe rise and dq feedback, with an apb register file
// assumes command, strobe, odt and clock pins from the controller domain
//
// Functional notes
// (RQ1) mr1 a7 set enters, cleared leaves leveling
// (RQ2) mr1 a12 disables output buffers when set
// (RQ3) odt switches strobe termination only, dq never
// (RQ4) controller limits nominal termination with outputs on
// (RQ5) dq counts as undefined on entry
// (RQ6) controller sends only nop, deselect, allowed mrs
// (RQ7) exit write may update listed mr1 bits
// (RQ8) controller levels one rank, others a12 set
// (RQ9) odt accepted only tmod after entry
// (RQ10) strobe termination applied within twldqsen of odt
// (RQ11) controller pulses strobe after tdqsl and twlmrd
// (RQ12) strobe rise samples ck, drives dq within twlo
// (RQ13) feedback carries no read strobe
// (RQ14) controller sweeps delay, locks at 0-to-1
// (RQ15) single-bit feedback holds other dq bits low
// (RQ16) each byte lane reports its own strobe
// (RQ17) device terminates strobes, controller terminates dq
// (RQ18) controller stops strobes, dq undefined until tmod
// (RQ19) controller drops odt before exit write
// (RQ20) controller waits tmrd for mrs, tmod otherwise
// (RQ21) feedback holds until next strobe rise or exit
`timescale 1ns/100ps
module wlm_write_leveling #(
  parameter int unsigned DQ_W = 16,
  parameter int unsigned LANE_W = 8,
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller clock, strobes and odt pins
  input wire logic ctrl_clock,
  input wire logic upper_lane_strobe_pair,
  input wire logic lower_lane_strobe_pair,
  input wire logic odt,
  // mode register write command pins
  input wire logic mrs_strobe,
  input wire logic [2:0] mr_select,
  input wire logic [15:0] mr_addr,
  // dq feedback and termination
  output logic [DQ_W-1:0] dq_out,
  output logic [DQ_W-1:0] dq_oe,
  output logic strobe_term_en,
  output logic dq_term_en,
  output logic read_strobe_oe
);

  localparam int MOD_LIM = wlm_pkg::MOD_CYC;
  localparam int WLDQSEN_LIM = wlm_pkg::WLDQSEN_CYC;
  localparam int WLO_LIM = wlm_pkg::WLO_CYC;
  localparam int WLO_LAST = wlm_pkg::WLO_CYC - 1;

  typedef struct packed {
    wlm_pkg::wlm_mode_t mode;
    logic [15:0] mr1;
    logic [CNT_W-1:0] cnt;
    logic odt_ok;
    logic upper_sample;
    logic lower_sample;
    logic dq_undef;
    logic strobe_term;
    logic dq_term;
    logic read_strobe;
    logic [DQ_W-1:0] dq_out;
    logic [DQ_W-1:0] dq_oe;
    logic prime_only;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wlm_state_t;

  wlm_state_t r;
  wlm_state_t next_r;

  logic [wlm_pkg::IN_W-1:0] pin_raw;
  logic [wlm_pkg::IN_W-1:0] pin_lvl;
  logic [wlm_pkg::IN_W-1:0] pin_rise;
  logic ck_lvl;
  logic odt_lvl;
  logic us_rise;
  logic ls_rise;
  logic mr_hit;
  logic leveling;

  assign pin_raw = {mrs_strobe, odt, lower_lane_strobe_pair,
    upper_lane_strobe_pair, ctrl_clock};

  // one synchroniser for ck, strobes, odt and mrs keeps ck and strobe latency equal
  wlm_sync #(
    .WIDTH(wlm_pkg::IN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_raw),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  assign ck_lvl = pin_lvl[wlm_pkg::IN_CK];
  assign odt_lvl = pin_lvl[wlm_pkg::IN_ODT];
  assign us_rise = pin_rise[wlm_pkg::IN_US];
  assign ls_rise = pin_rise[wlm_pkg::IN_LS];
  // address pins are held by the command, so they are read unsynchronised
  assign mr_hit = pin_rise[wlm_pkg::IN_MRS] && (mr_select == wlm_pkg::MR1_SEL);
  assign leveling = (r.mode == wlm_pkg::WLM_ON);

  always_comb begin
    logic [DQ_W-1:0] fb;
    logic [31:0] status;
    logic lane_bit;
    fb = '0;
    status = '0;
    lane_bit = 1'b0;
    next_r = r;

    // apb: answer one cycle into the access phase
    if (psel && penable && r.pready) begin
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      if (pwrite && !r.pslverr &&
          (paddr[wlm_pkg::ADDR_W-1:0] == wlm_pkg::CTRL_OFS)) begin
        next_r.prime_only = pwdata[wlm_pkg::CTRL_PRIME_BIT];
      end
    end else if (psel && penable) begin
      status[wlm_pkg::ST_LEVEL] = leveling;
      status[wlm_pkg::ST_QOFF] = r.mr1[wlm_pkg::MR1_QOFF_BIT];
      status[wlm_pkg::ST_TERM] = r.strobe_term;
      status[wlm_pkg::ST_ODT_OK] = r.odt_ok;
      status[wlm_pkg::ST_UNDEF] = r.dq_undef;
      status[wlm_pkg::ST_UPPER] = r.upper_sample;
      status[wlm_pkg::ST_LOWER] = r.lower_sample;
      status[wlm_pkg::ST_EXIT] = (r.mode == wlm_pkg::WLM_EXIT);
      next_r.pready = 1'b1;
      next_r.pslverr = 1'b0;
      next_r.prdata = '0;
      unique case (paddr[wlm_pkg::ADDR_W-1:0])
        wlm_pkg::CTRL_OFS: begin
          next_r.prdata[wlm_pkg::CTRL_PRIME_BIT] = r.prime_only;
        end
        wlm_pkg::STATUS_OFS: begin
          next_r.prdata = status;
          next_r.pslverr = pwrite;
        end
        wlm_pkg::MR1_OFS: begin
          next_r.prdata[15:0] = r.mr1;
          next_r.pslverr = pwrite;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end else begin
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
    end

    // mode sequencing
    unique case (r.mode)
      wlm_pkg::WLM_OFF, wlm_pkg::WLM_EXIT: begin
        if (r.mode == wlm_pkg::WLM_EXIT) begin
          if (r.cnt != '0) begin
            next_r.cnt = r.cnt - CNT_W'(1);
          end else begin
            next_r.mode = wlm_pkg::WLM_OFF;
            next_r.dq_undef = 1'b0;
          end
        end
        if (mr_hit) begin
          next_r.mr1 = mr_addr;
          if (mr_addr[wlm_pkg::MR1_LEVEL_BIT]) begin
            next_r.mode = wlm_pkg::WLM_ON; // RQ1
            next_r.cnt = CNT_W'(wlm_pkg::MOD_CYC);
            next_r.odt_ok = 1'b0;
            next_r.dq_undef = 1'b1; // RQ5
            next_r.upper_sample = 1'b0;
            next_r.lower_sample = 1'b0;
          end
        end
      end
      wlm_pkg::WLM_ON: begin
        // odt is ignored until tmod after entry
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end else begin
          next_r.odt_ok = 1'b1; // RQ9
        end
        // sample ck on each strobe rise and keep it until the next
        if (us_rise) begin
          next_r.upper_sample = ck_lvl; // RQ12 RQ21
          next_r.dq_undef = 1'b0;
        end
        if (ls_rise) begin
          next_r.lower_sample = ck_lvl; // RQ12 RQ21
          next_r.dq_undef = 1'b0;
        end
        if (mr_hit) begin
          if (!mr_addr[wlm_pkg::MR1_LEVEL_BIT]) begin
            // exit may also update the listed fields
            next_r.mr1 = (r.mr1 & ~wlm_pkg::MR1_EXIT_MASK) |
              (mr_addr & wlm_pkg::MR1_EXIT_MASK); // RQ1 RQ7
            next_r.mode = wlm_pkg::WLM_EXIT;
            next_r.cnt = CNT_W'(wlm_pkg::MOD_CYC);
            next_r.odt_ok = 1'b0;
            next_r.dq_undef = 1'b1;
            next_r.upper_sample = 1'b0; // RQ21
            next_r.lower_sample = 1'b0; // RQ21
          end else begin
            next_r.mr1[wlm_pkg::MR1_QOFF_BIT] =
              mr_addr[wlm_pkg::MR1_QOFF_BIT]; // RQ2
          end
        end
      end
      // the spare code of the mode field falls back to off
      default: begin
        next_r.mode = wlm_pkg::WLM_OFF;
      end
    endcase

    // feedback: lane bit 0 always, the others only in all-bit mode
    for (int i = 0; i < DQ_W; i++) begin
      lane_bit = (i >= LANE_W) ? r.upper_sample : r.lower_sample; // RQ16
      if (!r.prime_only || ((i % LANE_W) == 0)) begin
        fb[i] = lane_bit; // RQ15
      end
    end
    next_r.dq_out = leveling ? fb : '0; // RQ12
    next_r.dq_oe = {DQ_W{leveling && !r.mr1[wlm_pkg::MR1_QOFF_BIT]}}; // RQ2

    // in leveling odt steers the strobe terminators alone
    next_r.strobe_term = leveling && r.odt_ok && odt_lvl; // RQ3 RQ10 RQ17
    next_r.dq_term = 1'b0; // RQ3
    next_r.read_strobe = 1'b0; // RQ13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.mode <= wlm_pkg::WLM_OFF;
      r.mr1 <= wlm_pkg::MR1_RESET;
      r.prime_only <= wlm_pkg::CTRL_PRIME_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign dq_out = r.dq_out;
  assign dq_oe = r.dq_oe;
  assign strobe_term_en = r.strobe_term;
  assign dq_term_en = r.dq_term;
  assign read_strobe_oe = r.read_strobe;

  wl_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (!leveling && mr_hit && mr_addr[wlm_pkg::MR1_LEVEL_BIT])
    |=> leveling && r.dq_undef)
    else $error("leveling not entered on mr1 a7 set");

  wl_exit_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (leveling && mr_hit && !mr_addr[wlm_pkg::MR1_LEVEL_BIT])
    |=> (r.mode == wlm_pkg::WLM_EXIT) && !r.mr1[wlm_pkg::MR1_LEVEL_BIT]
    ##1 !leveling ##1 (dq_oe == '0))
    else $error("leveling not left on mr1 a7 clear");

  exit_update_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (leveling && mr_hit && !mr_addr[wlm_pkg::MR1_LEVEL_BIT])
    |=> ((r.mr1 & wlm_pkg::MR1_EXIT_MASK) ==
    ($past(mr_addr) & wlm_pkg::MR1_EXIT_MASK)))
    else $error("exit write fields not applied");

  qoff_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    leveling && $past(leveling)
    |=> (dq_oe == {DQ_W{!$past(r.mr1[wlm_pkg::MR1_QOFF_BIT])}}))
    else $error("output enable disagrees with mr1 a12");

  dq_term_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    !dq_term_en && !read_strobe_oe) // RQ13
    else $error("dq termination or read strobe driven");

  odt_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    $rose(leveling) |-> (!strobe_term_en && !r.odt_ok)[*2]
    ##[1:MOD_LIM] r.odt_ok)
    else $error("odt accepted before tmod or never");

  term_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (leveling && r.odt_ok && $rose(odt_lvl) && !mr_hit)
    |-> ##[1:WLDQSEN_LIM] strobe_term_en)
    else $error("strobe termination late after odt");

  sample_ck_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    (leveling && us_rise && !mr_hit)
    |=> (r.upper_sample == $past(ck_lvl)) ##1 (dq_out[LANE_W] == $past(
    r.upper_sample)))
    else $error("upper lane feedback not the sampled ck");

  feedback_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    (leveling && ls_rise && !mr_hit) // RQ12
    |=> (r.lower_sample == $past(ck_lvl))
    ##[1:WLO_LAST] (dq_out[0] == r.lower_sample))
    else $error("lower lane feedback later than twlo");

  prime_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    (leveling && r.prime_only) |=> ((dq_out & ~{{(DQ_W-LANE_W-1){1'b0}},
    1'b1, {(LANE_W-1){1'b0}}, 1'b1}) == '0))
    else $error("non-feedback dq bits not low");

  hold_sample_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
    (leveling && !us_rise && !mr_hit) |=> $stable(r.upper_sample))
    else $error("feedback changed without strobe rise");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer not one cycle into access");

endmodule // wlm_write_leveling

// *** testbench/wlm_ctrl_model.sv ***
// controller-side partner: free ck, strobes, odt, mode register writes
// assumes the bench calls its tasks; pins move just after pclk rises
`timescale 1ns/100ps
module wlm_ctrl_model (
  // clock
  input wire logic pclk,
  // pins toward the device
  output logic ctrl_clock,
  output logic upper_lane_strobe_pair,
  output logic lower_lane_strobe_pair,
  output logic odt,
  output logic mrs_strobe,
  output logic [2:0] mr_select,
  output logic [15:0] mr_addr
);
  logic [2:0] ph = 3'h0;
  always @(posedge pclk) ph <= ph + 3'h1;
  // ck runs free, eight pclk a period
  assign ctrl_clock = ph[2];
  initial begin
    upper_lane_strobe_pair = 1'b0;
    lower_lane_strobe_pair = 1'b0;
    odt = 1'b0;
    mrs_strobe = 1'b0;
    mr_select = 3'h0;
    mr_addr = 16'h0000;
  end
  // only mode register writes are sent; strobe held long enough to sync
  task automatic mrs(input logic [15:0] v);
    @(posedge pclk);
    mr_select <= 3'h1;
    mr_addr <= v;
    @(posedge pclk);
    mrs_strobe <= 1'b1;
    repeat (6) @(posedge pclk);
    mrs_strobe <= 1'b0;
    repeat (6) @(posedge pclk);
    // released address pins show the inverse, not the last value; select goes to 0
    mr_select <= 3'h0;
    mr_addr <= ~v;
  endtask
  task automatic set_odt(input logic v);
    @(posedge pclk);
    odt <= v;
  endtask
  // one rise at ck phase d, strobes otherwise parked low
  task automatic pulse(input logic up, input logic [2:0] d,
      input int unsigned hold);
    int n;
    n = 0;
    // ck phase comes round within eight pclk
    do begin
      @(posedge pclk);
      n++;
    end while (ph != d - 3'h1 && n < 9);
    if (up) upper_lane_strobe_pair <= 1'b1;
    else lower_lane_strobe_pair <= 1'b1;
    repeat (hold) @(posedge pclk);
    upper_lane_strobe_pair <= 1'b0;
    lower_lane_strobe_pair <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule // wlm_ctrl_model

// *** testbench/wlm_write_leveling_test.sv ***
// self-checking bench for the write leveling block
// assumes wlm_ctrl_model drives the controller pins; bench owns apb
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module wlm_write_leveling_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ctrl_clock, odt, mrs_strobe;
  logic upper_lane_strobe_pair, lower_lane_strobe_pair;
  logic [2:0] mr_select;
  logic [15:0] mr_addr, dq_out, dq_oe;
  logic strobe_term_en, dq_term_en, read_strobe_oe;
  int num_errors = 0;
  int checks = 0;
  logic [32:0] exp_q[$], msk_q[$];
  logic [31:0] rnd = 32'h10;
  logic [15:0] mr_exp, v;
  logic prev, lvl;
  logic [2:0] d, lock_d;
  logic [2:0] ds [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  localparam logic [32:0] ALL = 33'h1_ffff_ffff;
  // assumed permitted nominal termination code
  localparam logic [15:0] NOM_TERM = 16'h0004;
  always #25 pclk = ~pclk;
  wlm_write_leveling dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctrl_clock(ctrl_clock),
    .upper_lane_strobe_pair(upper_lane_strobe_pair),
    .lower_lane_strobe_pair(lower_lane_strobe_pair), .odt(odt),
    .mrs_strobe(mrs_strobe), .mr_select(mr_select), .mr_addr(mr_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .strobe_term_en(strobe_term_en),
    .dq_term_en(dq_term_en), .read_strobe_oe(read_strobe_oe)
  );
  wlm_ctrl_model ctrl (
    .pclk(pclk), .ctrl_clock(ctrl_clock),
    .upper_lane_strobe_pair(upper_lane_strobe_pair),
    .lower_lane_strobe_pair(lower_lane_strobe_pair), .odt(odt),
    .mrs_strobe(mrs_strobe), .mr_select(mr_select), .mr_addr(mr_addr)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, input logic [32:0] e, input logic [32:0] m);
    int n;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e,
      input logic [32:0] m);
    apb(1'b0, a, rnd, e, m);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd,
      input logic err);
    apb(1'b1, a, wd, {err, 32'h0}, 33'h1_0000_0000);
  endtask
  task automatic wait_term(input logic t);
    int n;
    n = 0;
    while (strobe_term_en !== t && n < 40) begin
      @(posedge pclk);
      n++;
    end
    `CHK(strobe_term_en, t)
    if (n >= 40) give_verdict();
  endtask
  // answer watcher: oldest note against each pready
  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      `CHK({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(wlm_pkg::CTRL_OFS, 33'h0, ALL);
    rd(wlm_pkg::STATUS_OFS, 33'h0, ALL);
    rd(wlm_pkg::MR1_OFS, 33'h0, ALL);
    rd(12'h00c, 33'h1_0000_0000, ALL);
    wr(wlm_pkg::STATUS_OFS, rnd, 1'b1);
    mr_exp = 16'h0080 | NOM_TERM;
    // odt raised before entry must stay ignored until tmod has passed
    ctrl.set_odt(1'b1);
    ctrl.mrs(mr_exp);
    rd(wlm_pkg::STATUS_OFS, 33'h11, 33'h1f);
    `CHK(strobe_term_en, 1'b0)
    wait_term(1'b1);
    `CHK(dq_term_en, 1'b0)
    rd(wlm_pkg::STATUS_OFS, 33'h1d, ALL);
    repeat (wlm_pkg::WLDQSEN_CYC) @(posedge pclk);
    prev = 1'b0;
    lock_d = 3'h0;
    foreach (ds[i]) begin
      ctrl.pulse(1'b1, ds[i], wlm_pkg::WLO_CYC);
      lvl = ds[i][2];
      `CHK(dq_out, {{8{lvl}}, 8'h00})
      `CHK({dq_oe, read_strobe_oe}, {16'hffff, 1'b0})
      if (!prev && lvl && lock_d == 3'h0) lock_d = ds[i];
      prev = lvl;
    end
    `CHK(lock_d, 3'h5)
    repeat (4) begin
      rnd = xs(rnd);
      d = {rnd[2], (rnd[1:0] == 2'h0) ? 2'h1 : rnd[1:0]};
      ctrl.pulse(1'b0, d, wlm_pkg::WLO_CYC);
      `CHK(dq_out, {8'hff, {8{d[2]}}})
    end
    rnd = xs(rnd);
    wr(wlm_pkg::CTRL_OFS, rnd | 32'h1, 1'b0);
    rd(wlm_pkg::CTRL_OFS, 33'h1, ALL);
    ctrl.pulse(1'b1, 3'h6, wlm_pkg::WLO_CYC);
    ctrl.pulse(1'b0, 3'h2, wlm_pkg::WLO_CYC);
    `CHK(dq_out, 16'h0100)
    rd(wlm_pkg::STATUS_OFS, 33'h2d, ALL);
    wr(wlm_pkg::CTRL_OFS, 32'h0, 1'b0);
    ctrl.set_odt(1'b0);
    wait_term(1'b0);
    ctrl.set_odt(1'b1);
    wait_term(1'b1);
    // other ranks would be parked the same way, a12 set
    ctrl.mrs(mr_exp | 16'h1003);
    mr_exp = mr_exp | 16'h1000;
    rd(wlm_pkg::MR1_OFS, {17'h0, mr_exp}, ALL);
    `CHK(dq_oe, 16'h0000)
    mr_exp = mr_exp & 16'hefff;
    ctrl.mrs(mr_exp);
    `CHK(dq_oe, 16'hffff)
    ctrl.set_odt(1'b0);
    wait_term(1'b0);
    rnd = xs(rnd);
    v = rnd[15:0] & 16'hff7f;
    mr_exp = (mr_exp & ~wlm_pkg::MR1_EXIT_MASK) |
      (v & wlm_pkg::MR1_EXIT_MASK);
    ctrl.mrs(v);
    rd(wlm_pkg::STATUS_OFS, 33'h90 | {31'h0, mr_exp[12], 1'b0},
      33'h97);
    rd(wlm_pkg::MR1_OFS, {17'h0, mr_exp}, ALL);
    repeat (wlm_pkg::MOD_CYC + 1) @(posedge pclk);
    rd(wlm_pkg::STATUS_OFS, 33'h0, 33'h81);
    // a plain mr1 write outside leveling only loads the shadow
    rnd = xs(rnd);
    v = rnd[15:0] & 16'hff7f;
    ctrl.mrs(v);
    rd(wlm_pkg::MR1_OFS, {17'h0, v}, ALL);
    `CHK(dq_oe, 16'h0000)
    give_verdict();
  end
endmodule // wlm_write_leveling_test
